// [design/divider_sync_control.sv]
// Sync control register, its three-wire serial access port and the sync pulse gate.
// Assumes serial port pins and the sync input are synchronous to i_ref_clk.
//
// Functional notes
// - All sync functions stay off unless the main sync enable bit is set.
// - Pulses reach the divider only while divider sync and main enables are high.
// - In one-shot mode only the first pulse realigns the divider.
// - One-shot mode clears the divider sync enable bit after it realigns.
`timescale 1ns/1ps

module divider_sync_control
  import sync_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Three-wire serial port.
  input  wire logic i_sclk,
  input  wire logic i_csb_n,
  input  wire logic i_sdio,
  output logic      o_sdio,
  output logic      o_sdio_oe,
  // Sync input and divider side.
  input  wire logic i_sync,
  output logic      o_sync_buf_en,
  output logic      o_div_realign
);

  typedef struct packed {
    port_state_e     state;
    logic [4:0]      bit_cnt;
    logic [15:0]     instr;
    logic [7:0]      data;
    logic [7:0]      rd_shift;
    logic            sclk_q;
    logic            sync_q;
    logic            main_en;
    logic            div_sync_en;
    logic            next_only;
    logic            realign;
    logic            sdio_out;
    logic            sdio_oe;
  } state_s;

  state_s cur;
  state_s next_cur;

  // Returns the read-back value of an address; only the low control bits exist.
  function automatic logic [7:0] read_value(input logic [12:0] addr,
                                            input logic [2:0]  ctrl);
    logic [7:0] val;
    val = UNMAPPED_RD;
    if (addr == ADDR_SYNC_CTRL) begin
      val = {{(DATA_BITS - CTRL_USED){1'b0}}, ctrl};
    end
    return val;
  endfunction : read_value

  logic        sclk_rise;
  logic        sclk_fall;
  logic        sync_rise;
  logic        sync_go;
  logic        wr_ctrl;
  logic [15:0] instr_full;
  logic [7:0]  wdata_full;
  logic [2:0]  ctrl_now;

  // The host clock is oversampled by the reference clock, so each host clock
  // phase must last at least one reference clock or an edge is lost.
  assign sclk_rise  = i_sclk & ~cur.sclk_q;
  assign sclk_fall  = ~i_sclk & cur.sclk_q;
  assign instr_full = {cur.instr[INSTR_BITS-2:0], i_sdio};
  assign wdata_full = {cur.data[DATA_BITS-2:0], i_sdio};
  assign ctrl_now   = {cur.next_only, cur.div_sync_en, cur.main_en};
  // The sync input is looked at only while the main buffer is on.
  assign sync_rise  = i_sync & cur.main_en & ~cur.sync_q;
  assign sync_go    = sync_rise & cur.div_sync_en;
  assign wr_ctrl    = ~i_csb_n && (cur.state == ST_DATA) && sclk_rise
                      && (cur.bit_cnt == DATA_LAST) && ~cur.instr[RW_BIT]
                      && (cur.instr[ADDR_BITS-1:0] == ADDR_SYNC_CTRL);

  always_comb begin
    next_cur          = cur;
    next_cur.sclk_q   = i_sclk;
    next_cur.sync_q   = i_sync & cur.main_en;
    next_cur.realign  = 1'b0;

    if (sync_go) begin
      next_cur.realign = 1'b1;
      if (cur.next_only) begin
        // Later pulses find the gate closed, so only the first one counts.
        next_cur.div_sync_en = 1'b0;
      end
    end

    // Serial frame: sixteen instruction bits, then one data byte, both MSB first.
    // Raising the chip select abandons the frame and releases the data pin.
    if (i_csb_n) begin
      next_cur.state   = ST_IDLE;
      next_cur.bit_cnt = '0;
      next_cur.sdio_oe = 1'b0;
    end else begin
      case (cur.state)
        ST_IDLE, ST_INSTR: begin
          next_cur.state = ST_INSTR;
          if (sclk_rise) begin
            next_cur.instr   = instr_full;
            next_cur.bit_cnt = cur.bit_cnt + 5'h01;
            if (cur.bit_cnt == INSTR_LAST) begin
              next_cur.state    = ST_DATA;
              next_cur.bit_cnt  = '0;
              next_cur.rd_shift = read_value(instr_full[ADDR_BITS-1:0], ctrl_now);
            end
          end
        end
        ST_DATA: begin
          if (sclk_fall && cur.instr[RW_BIT]) begin
            next_cur.sdio_out = cur.rd_shift[DATA_BITS-1];
            next_cur.rd_shift = {cur.rd_shift[DATA_BITS-2:0], 1'b0};
            next_cur.sdio_oe  = 1'b1;
          end
          if (sclk_rise) begin
            next_cur.data    = wdata_full;
            next_cur.bit_cnt = cur.bit_cnt + 5'h01;
            if (cur.bit_cnt == DATA_LAST) begin
              next_cur.state = ST_DONE;
            end
          end
          if (wr_ctrl) begin
            // A host write overrides a same-cycle one-shot clear; upper bits are dropped.
            next_cur.main_en     = wdata_full[MAIN_EN_BIT];
            next_cur.div_sync_en = wdata_full[DIV_SYNC_BIT];
            next_cur.next_only   = wdata_full[NEXT_ONLY_BIT];
          end
        end
        ST_DONE: begin
          if (sclk_fall) begin
            next_cur.sdio_oe = 1'b0;
          end
        end
        default: begin
          next_cur.state = ST_IDLE;
        end
      endcase
    end

    // Reset is applied last so that it overrides every update above.
    // The control bits return to their default, which keeps the sync path off.
    if (!i_rst_n) begin
      next_cur             = '0;
      next_cur.state       = ST_IDLE;
      next_cur.main_en     = SYNC_CTRL_RST[MAIN_EN_BIT];
      next_cur.div_sync_en = SYNC_CTRL_RST[DIV_SYNC_BIT];
      next_cur.next_only   = SYNC_CTRL_RST[NEXT_ONLY_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    cur <= next_cur;
  end

  assign o_sdio        = cur.sdio_out;
  assign o_sdio_oe     = cur.sdio_oe;
  assign o_sync_buf_en = cur.main_en;
  assign o_div_realign = cur.realign;

  // Checks.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Every check is disabled while i_rst_n is low, so the reset window is left out.

  main_gate_a: assert property (!cur.main_en |=> !cur.realign)
    else $error("Divider realigned while the main sync buffer was off.");

  realign_cause_a: assert property (cur.realign |-> $past(sync_go))
    else $error("Divider realign without an enabled sync edge.");

  pulse_pass_a: assert property (sync_go |=> cur.realign ##1 !cur.realign)
    else $error("Enabled sync edge did not give one realign pulse.");

  oneshot_once_a: assert property ((sync_go && cur.next_only && !wr_ctrl)
                                   |=> !sync_go ##1 (!sync_go || $past(wr_ctrl)))
    else $error("One-shot mode passed a second sync pulse.");

  oneshot_clear_a: assert property ((sync_go && cur.next_only && !wr_ctrl)
                                    |=> !cur.div_sync_en)
    else $error("Divider sync enable not cleared after one-shot sync.");

  // The read-back byte is loaded as the instruction completes; upper bits must be zero.
  reserved_zero_a: assert property ($rose(cur.state == ST_DATA) && cur.instr[RW_BIT]
                                    && (cur.instr[ADDR_BITS-1:0] == ADDR_SYNC_CTRL)
                                    |-> cur.rd_shift == {{(DATA_BITS - CTRL_USED){1'b0}},
                                                         $past(ctrl_now)})
    else $error("Reserved sync control bits read nonzero.");

  ctrl_write_a: assert property (wr_ctrl |=> (cur.main_en == $past(i_sdio)))
    else $error("Main enable did not take the written value.");

  ctrl_bits_a: assert property (wr_ctrl
                                |=> ctrl_now == $past(wdata_full[CTRL_USED-1:0]))
    else $error("Sync control bits did not take the written low bits.");

  div_gate_a: assert property (!cur.div_sync_en |=> !cur.realign)
    else $error("Divider realigned while divider sync enable was off.");

  sync_idle_a: assert property (!cur.main_en |=> !cur.sync_q)
    else $error("Sync input history kept while the main buffer was off.");

  cont_keep_a: assert property ((sync_go && !cur.next_only && !wr_ctrl)
                                |=> cur.div_sync_en)
    else $error("Continuous sync mode closed the divider gate.");

  // Main scenarios the bench is expected to reach.
  realign_c: cover property (sync_go && !cur.next_only);
  oneshot_c: cover property (sync_go && cur.next_only);
  readback_c: cover property (cur.sdio_oe && cur.instr[ADDR_BITS-1:0] == ADDR_SYNC_CTRL);
  reserved_wr_c: cover property (wr_ctrl && (wdata_full[DATA_BITS-1:CTRL_USED] != '0));
  gate_shut_c: cover property (sync_rise && !cur.div_sync_en);

endmodule : divider_sync_control

// [design/sync_ctrl_pkg.sv]
// Constants, the port state type and register layout for the divider sync control block.
// Assumes a single sample-clock domain and a three-wire serial host port.
package sync_ctrl_pkg;

  // Serial port framing.
  localparam int unsigned INSTR_BITS   = 16;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned ADDR_BITS    = 13;
  localparam int unsigned RW_BIT       = 15;
  localparam logic [4:0]  INSTR_LAST   = 5'h0F;
  localparam logic [4:0]  DATA_LAST    = 5'h07;

  // Sync control register.
  localparam logic [12:0] ADDR_SYNC_CTRL = 13'h003A;
  localparam logic [7:0]  SYNC_CTRL_RST  = 8'h00;
  localparam int unsigned MAIN_EN_BIT    = 0;
  localparam int unsigned DIV_SYNC_BIT   = 1;
  localparam int unsigned NEXT_ONLY_BIT  = 2;
  localparam int unsigned CTRL_USED      = 3;
  localparam logic [7:0]  UNMAPPED_RD    = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_DONE  = 4'b1000
  } port_state_e;

endpackage : sync_ctrl_pkg

// [bench/sync_host_model.sv]
// Partner model: three-wire serial host and sync pulse source.
// Assumes the bench resolves the sdio pin level and feeds it back.
`timescale 1ns/1ps

module sync_host_model
  import sync_ctrl_pkg::*;
(
  // Clock and pin level.
  input  wire logic i_ref_clk,
  input  wire logic i_sdio_pin,
  // Host and sync pins.
  output logic      o_sclk,
  output logic      o_csb_n,
  output logic      o_sdio,
  output logic      o_sdio_en,
  output logic      o_sync
);
  initial {o_sclk, o_csb_n, o_sdio, o_sdio_en, o_sync} = 5'h08;
  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : tick
  // Each frame is sent whole; the port idles between frames.
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 2'h0, a, wd};
    o_csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_sdio_en = !(rd && i < 8);
      o_sdio = f[i];
      tick(2);
      o_sclk = 1'b1;
      tick(2);
      q[i%8] = i_sdio_pin;
    end
    o_sclk = 1'b0;
    o_sdio_en = 1'b0;
    tick(2);
    o_csb_n = 1'b1;
    tick(2);
  endtask : xfer
  task automatic pulse();
    o_sync = 1'b1;
    tick(2);
    o_sync = 1'b0;
    tick(3);
  endtask : pulse
endmodule : sync_host_model

// [bench/tb_top.sv]
// Self-checking bench for the divider sync control block.
// Assumes the host model drives the serial port and the sync input.
`timescale 1ns/1ps

module tb_top
  import sync_ctrl_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       lastv = 1'b0;
  wire        sclk, csb_n, h_sdio, h_en, sync, sdio_pin;
  logic       dev_sdio, dev_oe, buf_en, realign;
  logic [7:0] v, q, base;
  logic [7:0] rcnt = 8'h00;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cycles = 0;
  integer     seed = 32'h5791F6F7;
  logic [7:0] corner [4] = '{8'h03, 8'h07, 8'hFF, 8'h02};
  // An undriven pin flips every cycle so no stale value passes as data.
  assign sdio_pin = dev_oe ? dev_sdio : (h_en ? h_sdio : ~lastv);
  always #5 clk = ~clk;
  always @(posedge clk) lastv <= sdio_pin;
  always @(posedge clk) if (realign === 1'b1) rcnt <= rcnt + 8'h01;
  divider_sync_control uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk),
    .i_csb_n(csb_n), .i_sdio(sdio_pin), .o_sdio(dev_sdio), .o_sdio_oe(dev_oe),
    .i_sync(sync), .o_sync_buf_en(buf_en), .o_div_realign(realign));
  sync_host_model host (.i_ref_clk(clk), .i_sdio_pin(sdio_pin), .o_sclk(sclk),
    .o_csb_n(csb_n), .o_sdio(h_sdio), .o_sdio_en(h_en), .o_sync(sync));
  function automatic logic [7:0] exp_pulses(input logic [7:0] w);
    return (w[0] && w[1]) ? (w[2] ? 8'h01 : 8'h02) : 8'h00;
  endfunction : exp_pulses
  function automatic logic [7:0] exp_reg(input logic [7:0] w);
    return (w & 8'h07) & ~{6'h00, w[0] & w[1] & w[2], 1'b0};
  endfunction : exp_reg
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    host.xfer(1'b1, ADDR_SYNC_CTRL, 8'h00, q);
    check("reset_value", q, SYNC_CTRL_RST);
    host.xfer(1'b0, 13'h0055, 8'hA5, q);
    host.xfer(1'b1, 13'h0055, 8'h00, q);
    check("unmapped", q, UNMAPPED_RD);
    for (int i = 0; i < 10; i++) begin
      v = (i < 4) ? corner[i] : 8'($random(seed));
      host.xfer(1'b0, ADDR_SYNC_CTRL, v, q);
      check("buf_en", {7'h00, buf_en}, {7'h00, v[0]});
      base = rcnt;
      host.pulse();
      host.pulse();
      check("realign", rcnt - base, exp_pulses(v));
      host.xfer(1'b1, ADDR_SYNC_CTRL, 8'h00, q);
      check("readback", q, exp_reg(v));
      $display("test %0d done, value %h", i, v);
    end
    // A reset in mid-run must close the sync path and clear the register.
    host.xfer(1'b0, ADDR_SYNC_CTRL, 8'h07, q);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("reset_buf_en", {7'h00, buf_en}, 8'h00);
    base = rcnt;
    host.pulse();
    check("reset_realign", rcnt - base, 8'h00);
    host.xfer(1'b1, ADDR_SYNC_CTRL, 8'h00, q);
    check("reset_readback", q, SYNC_CTRL_RST);
    $display("mid-run reset test done");
    host.xfer(1'b0, ADDR_SYNC_CTRL, 8'h00, q);
    end_of_test();
  end
endmodule : tb_top
